// ===== design/charger_control_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "charger_defs.vh"

// How it works
// - charge-current code 0..7 picks sense target 37.4 to 98.6 mV.
// - low-current-cap bit set caps sense target at 34.0 mV.
// - current termination happens only while termination-enable bit is one.
// - termination code picks threshold 3.3 mV times code plus one.
// - below threshold: stop switching, report ready ~500 ms, then done if connected.
// - supply above valid threshold switches the 100 ohm load on while validating.
// - charging starts only after 30 ms of continuously valid supply, or on watchdog expiry.
// - every start or restart except watchdog expiry runs the full validation interval first.
// - unattended 15-minute timer starts when charging begins while the watchdog is not running.
// - any register write clears unattended timer, starts 32-second watchdog.
// - writing the kick bit restarts the watchdog from zero.
// - watchdog expiry: defaults, fault 110, status pulse, resume unattended.
// - unattended expiry: charger off, charge-disable set, fault 110.
// - with no write since power-on the OTG pin sets input limit.
// - input-limit code gives 100, 500, 800 mA or no limit.
// - while unattended timer runs the OTG pin sets input limit.
// - write leaving charge-disable and high-impedance bits both clear, when either was set, starts a new cycle.
// - charge-current code above the ceiling is stored as the ceiling.
module charger_control_sequencer #(
    parameter [6:0]  DEV_ADDR        = 7'h35,
    parameter [2:0]  CURRENT_CEILING = 3'h7,
    parameter [39:0] VALID_CYC       = `VALID_CYC,
    parameter [39:0] READY_CYC       = `READY_CYC,
    parameter [39:0] WDOG_CYC        = `WDOG_CYC,
    parameter [39:0] UNATT_CYC       = `UNATT_CYC
) (
    input  wire       SYS_CLK,
    input  wire       RESETN,
    input  wire       SCL,
    input  wire       SDA_IN,
    output reg        SDA_OUT,
    output reg        SDA_OE,
    input  wire       OTG,
    input  wire       VBUS_ABOVE_MIN,
    input  wire       VBUS_OVER,
    input  wire       BAT_PRESENT,
    input  wire       TERM_BELOW,
    input  wire       RECHARGE_REQ,
    output reg        SWITCH_EN,
    output reg        VBUS_LOAD_EN,
    output reg [9:0]  SENSE_TARGET,
    output reg [9:0]  TERM_THRESHOLD,
    output reg [1:0]  INPUT_LIMIT,
    output reg [1:0]  CHARGE_STATE,
    output reg [2:0]  FAULT,
    output reg        STAT
);
    localparam [4:0] ST_VALIDATE = 5'h01;
    localparam [4:0] ST_CHARGE   = 5'h02;
    localparam [4:0] ST_READY    = 5'h04;
    localparam [4:0] ST_DONE     = 5'h08;
    localparam [4:0] ST_WAIT     = 5'h10;

    localparam [5:0] BS_IDLE = 6'h01;
    localparam [5:0] BS_ADDR = 6'h02;
    localparam [5:0] BS_PTR  = 6'h04;
    localparam [5:0] BS_WR   = 6'h08;
    localparam [5:0] BS_RD   = 6'h10;
    localparam [5:0] BS_SKIP = 6'h20;

    function [9:0] charge_mv;
        input [2:0] code;
        begin
            case (code)
                3'h0: charge_mv = 10'h176;
                3'h1: charge_mv = 10'h1BA;
                3'h2: charge_mv = 10'h1FE;
                3'h3: charge_mv = 10'h242;
                3'h4: charge_mv = 10'h2CA;
                3'h5: charge_mv = 10'h30E;
                3'h6: charge_mv = 10'h396;
                default: charge_mv = 10'h3DA;
            endcase
        end
    endfunction

    function [7:0] clamp_current;
        input [7:0] wdata;
        begin
            clamp_current = wdata;
            if (wdata[`ICHG_HI:`ICHG_LO] > CURRENT_CEILING) begin
                clamp_current[`ICHG_HI:`ICHG_LO] = CURRENT_CEILING;
            end
        end
    endfunction

    // input synchronisers: s1 read only by s2
    reg [7:0] in_s1_q;
    reg [7:0] in_s2_q;
    wire scl       = in_s2_q[0];
    wire sda       = in_s2_q[1];
    wire otg       = in_s2_q[2];
    wire above_min = in_s2_q[3];
    wire over_v    = in_s2_q[4];
    wire bat_ok    = in_s2_q[5];
    wire term_low  = in_s2_q[6];
    wire rechg     = in_s2_q[7];
    wire vbus_ok   = above_min & ~over_v;

    reg        scl_q;
    reg        sda_q;
    reg [5:0]  bst_q;
    reg [3:0]  bit_q;
    reg [7:0]  shift_q;
    reg [7:0]  tx_q;
    reg [7:0]  ptr_q;
    reg        wr_stb_q;
    reg [7:0]  wr_addr_q;
    reg [7:0]  wr_data_q;

    reg [7:0]  reg1_q;
    reg [7:0]  reg4_q;
    reg [7:0]  reg5_q;
    reg [2:0]  fault_q;
    reg [4:0]  st_q;
    reg [39:0] seq_cnt_q;
    reg        written_q;
    reg        unatt_run_q;
    reg [39:0] unatt_cnt_q;
    reg        wdog_run_q;
    reg [39:0] wdog_cnt_q;
    reg [15:0] stat_cnt_q;
    reg [1:0]  cstate;
    reg [7:0]  rdata;

    wire scl_rise = scl & ~scl_q;
    wire scl_fall = ~scl & scl_q;
    wire start_c  = scl & scl_q & sda_q & ~sda;
    wire stop_c   = scl & scl_q & ~sda_q & sda;

    always @* begin
        case (st_q)
            ST_CHARGE: cstate = `CST_CHARGING;
            ST_DONE:   cstate = `CST_DONE;
            default:   cstate = `CST_READY;
        endcase
    end

    always @* begin
        case (ptr_q)
            `REG_TIMER_FAULT: rdata = {2'h0, cstate, 1'b0, fault_q};
            `REG_INPUT_TERM:  rdata = reg1_q;
            `REG_CHARGE_CUR:  rdata = reg4_q;
            `REG_SPECIAL:     rdata = reg5_q;
            default:          rdata = 8'h00;
        endcase
    end

    always @(posedge SYS_CLK) begin
        if (!RESETN) begin
            in_s1_q <= 8'h03;
            in_s2_q <= 8'h03;
        end else begin
            in_s1_q <= {RECHARGE_REQ, TERM_BELOW, BAT_PRESENT, VBUS_OVER,
                        VBUS_ABOVE_MIN, OTG, SDA_IN, SCL};
            in_s2_q <= in_s1_q;
        end
    end

    // serial register port: address, pointer, then auto-increment data
    always @(posedge SYS_CLK) begin
        if (!RESETN) begin
            scl_q     <= 1'b1;
            sda_q     <= 1'b1;
            bst_q     <= BS_IDLE;
            bit_q     <= 4'h0;
            shift_q   <= 8'h00;
            tx_q      <= 8'h00;
            ptr_q     <= 8'h00;
            wr_stb_q  <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
            SDA_OUT   <= 1'b0;
            SDA_OE    <= 1'b0;
        end else begin
            scl_q    <= scl;
            sda_q    <= sda;
            wr_stb_q <= 1'b0;
            if (start_c) begin
                bst_q  <= BS_ADDR;
                // start's own scl fall wraps this to zero
                bit_q  <= 4'hF;
                SDA_OE <= 1'b0;
            end else if (stop_c) begin
                bst_q  <= BS_IDLE;
                SDA_OE <= 1'b0;
            end else if (scl_rise && bst_q != BS_IDLE) begin
                if (bit_q < 4'h8) begin
                    shift_q <= {shift_q[6:0], sda};
                end else if (bst_q == BS_RD && sda) begin
                    bst_q <= BS_SKIP;
                end
            end else if (scl_fall && bst_q != BS_IDLE && bst_q != BS_SKIP) begin
                if (bit_q == 4'h7) begin
                    bit_q  <= 4'h8;
                    SDA_OE <= 1'b0;
                    case (bst_q)
                        BS_ADDR: begin
                            if (shift_q[7:1] == DEV_ADDR) begin
                                SDA_OE <= 1'b1;
                                bst_q  <= shift_q[0] ? BS_RD : BS_PTR;
                            end else begin
                                bst_q <= BS_SKIP;
                            end
                        end
                        BS_PTR: begin
                            SDA_OE <= 1'b1;
                            ptr_q  <= shift_q;
                            bst_q  <= BS_WR;
                        end
                        BS_WR: begin
                            SDA_OE    <= 1'b1;
                            wr_stb_q  <= 1'b1;
                            wr_addr_q <= ptr_q;
                            wr_data_q <= shift_q;
                            ptr_q     <= ptr_q + 8'h01;
                        end
                        default: SDA_OE <= 1'b0;
                    endcase
                end else if (bit_q == 4'h8) begin
                    bit_q  <= 4'h0;
                    SDA_OE <= 1'b0;
                    if (bst_q == BS_RD) begin
                        tx_q   <= {rdata[6:0], 1'b0};
                        SDA_OE <= ~rdata[7];
                        ptr_q  <= ptr_q + 8'h01;
                    end
                end else begin
                    bit_q <= bit_q + 4'h1;
                    if (bst_q == BS_RD) begin
                        SDA_OE <= ~tx_q[7];
                        tx_q   <= {tx_q[6:0], 1'b0};
                    end
                end
            end
        end
    end

    // charge sequencer, control registers and safety timers
    always @(posedge SYS_CLK) begin
        if (!RESETN) begin
            reg1_q         <= `RST_INPUT_TERM;
            reg4_q         <= `RST_CHARGE_CUR;
            reg5_q         <= `RST_SPECIAL;
            fault_q        <= `FAULT_NONE;
            st_q           <= ST_VALIDATE;
            seq_cnt_q      <= 40'h0;
            written_q      <= 1'b0;
            unatt_run_q    <= 1'b0;
            unatt_cnt_q    <= 40'h0;
            wdog_run_q     <= 1'b0;
            wdog_cnt_q     <= 40'h0;
            stat_cnt_q     <= 16'h0;
            SWITCH_EN      <= 1'b0;
            VBUS_LOAD_EN   <= 1'b0;
            SENSE_TARGET   <= `VSNS_CAP;
            TERM_THRESHOLD <= `VTERM_STEP;
            INPUT_LIMIT    <= 2'h0;
            CHARGE_STATE   <= `CST_READY;
            FAULT          <= `FAULT_NONE;
            STAT           <= 1'b0;
        end else begin
            seq_cnt_q <= seq_cnt_q + 40'h1;
            if (stat_cnt_q != 16'h0) begin
                stat_cnt_q <= stat_cnt_q - 16'h1;
            end
            if (unatt_run_q) begin
                unatt_cnt_q <= unatt_cnt_q + 40'h1;
            end
            if (wdog_run_q) begin
                wdog_cnt_q <= wdog_cnt_q + 40'h1;
            end

            case (st_q)
                ST_VALIDATE: begin
                    if (!vbus_ok) begin
                        seq_cnt_q <= 40'h0;
                    end else if (seq_cnt_q >= VALID_CYC - 40'h1) begin
                        st_q <= ST_CHARGE;
                        if (!wdog_run_q) begin
                            unatt_run_q <= 1'b1;
                            unatt_cnt_q <= 40'h0;
                        end
                    end
                end
                ST_CHARGE: begin
                    if (term_low && reg1_q[`TE_BIT]) begin
                        st_q      <= ST_READY;
                        seq_cnt_q <= 40'h0;
                    end
                end
                ST_READY: begin
                    if (seq_cnt_q >= READY_CYC - 40'h1) begin
                        st_q      <= (bat_ok && vbus_ok) ? ST_DONE : ST_WAIT;
                        seq_cnt_q <= 40'h0;
                    end
                end
                ST_DONE: begin
                    if (rechg) begin
                        st_q      <= ST_VALIDATE;
                        seq_cnt_q <= 40'h0;
                    end
                end
                ST_WAIT: begin
                    if (bat_ok && vbus_ok) begin
                        st_q      <= ST_VALIDATE;
                        seq_cnt_q <= 40'h0;
                    end
                end
                default: st_q <= ST_VALIDATE;
            endcase
            // supply loss or overvoltage restarts validation
            if (!vbus_ok && st_q != ST_VALIDATE) begin
                st_q      <= ST_VALIDATE;
                seq_cnt_q <= 40'h0;
            end

            if (unatt_run_q && unatt_cnt_q >= UNATT_CYC - 40'h1) begin
                unatt_run_q      <= 1'b0;
                reg1_q[`CE_BIT]  <= 1'b1;
                fault_q          <= `FAULT_TIMER;
            end

            if (wdog_run_q && wdog_cnt_q >= WDOG_CYC - 40'h1) begin
                wdog_run_q  <= 1'b0;
                reg1_q      <= `RST_INPUT_TERM;
                reg4_q      <= `RST_CHARGE_CUR;
                reg5_q      <= `RST_SPECIAL;
                fault_q     <= `FAULT_TIMER;
                stat_cnt_q  <= `STAT_PULSE_CYC;
                unatt_run_q <= 1'b1;
                unatt_cnt_q <= 40'h0;
                st_q        <= ST_CHARGE;
            end

            if (wr_stb_q) begin
                written_q   <= 1'b1;
                unatt_run_q <= 1'b0;
                unatt_cnt_q <= 40'h0;
                wdog_run_q  <= 1'b1;
                wdog_cnt_q  <= 40'h0;
                if (wr_addr_q == `REG_TIMER_FAULT && wr_data_q[`KICK_BIT]) begin
                    wdog_cnt_q <= 40'h0;
                end
                case (wr_addr_q)
                    `REG_INPUT_TERM: begin
                        reg1_q <= wr_data_q;
                        if ((reg1_q[`CE_BIT] || reg1_q[`HZ_BIT]) &&
                            !wr_data_q[`CE_BIT] && !wr_data_q[`HZ_BIT]) begin
                            st_q      <= ST_VALIDATE;
                            seq_cnt_q <= 40'h0;
                            fault_q   <= `FAULT_NONE;
                        end
                    end
                    `REG_CHARGE_CUR: reg4_q <= clamp_current(wr_data_q);
                    `REG_SPECIAL:    reg5_q <= wr_data_q;
                    default:         reg5_q <= reg5_q;
                endcase
            end

            // load while validating and supply above valid threshold
            VBUS_LOAD_EN <= (st_q == ST_VALIDATE) && above_min;
            SWITCH_EN    <= (st_q == ST_CHARGE) && !reg1_q[`CE_BIT] && !reg1_q[`HZ_BIT];
            SENSE_TARGET <= reg5_q[`LOWCAP_BIT] ? `VSNS_CAP : charge_mv(reg4_q[`ICHG_HI:`ICHG_LO]);
            TERM_THRESHOLD <= `VTERM_STEP * ({7'h0, reg4_q[`TERMINATION_CODE_HI:`TERMINATION_CODE_LO]} + 10'h001);
            if (!written_q || unatt_run_q) begin
                INPUT_LIMIT <= {1'b0, otg};
            end else begin
                INPUT_LIMIT <= reg1_q[`ILIM_HI:`ILIM_LO];
            end
            CHARGE_STATE <= cstate;
            FAULT        <= fault_q;
            STAT         <= (stat_cnt_q != 16'h0);
        end
    end
endmodule
`default_nettype wire

// ===== design/charger_defs.vh
`ifndef CHARGER_DEFS_VH
`define CHARGER_DEFS_VH

// register offsets
`define REG_TIMER_FAULT   8'h00
`define REG_INPUT_TERM    8'h01
`define REG_CHARGE_CUR    8'h04
`define REG_SPECIAL       8'h05

// reset values
`define RST_INPUT_TERM    8'h30
`define RST_CHARGE_CUR    8'h01
`define RST_SPECIAL       8'h20

// field positions
`define KICK_BIT          7
`define ILIM_HI           7
`define ILIM_LO           6
`define TE_BIT            3
`define CE_BIT            2
`define HZ_BIT            1
`define ICHG_HI           6
`define ICHG_LO           4
`define TERMINATION_CODE_HI          2
`define TERMINATION_CODE_LO          0
`define LOWCAP_BIT        5

// charge state and fault codes
`define CST_READY         2'h0
`define CST_CHARGING      2'h1
`define CST_DONE          2'h2
`define FAULT_NONE        3'h0
`define FAULT_TIMER       3'h6

// sense voltages in 0.1 mV units
`define VSNS_CAP          10'h154
`define VTERM_STEP        10'h021

// timing
`define CLK_HZ            40'h00_0EE6_B280
`define T_VALID_MS        30
`define T_READY_MS        500
`define T_WDOG_S          32
`define T_UNATT_MIN       15
`define VALID_CYC         (`T_VALID_MS * `CLK_HZ / 1000)
`define READY_CYC         (`T_READY_MS * `CLK_HZ / 1000)
`define WDOG_CYC          (`T_WDOG_S * `CLK_HZ)
`define UNATT_CYC         (`T_UNATT_MIN * 60 * `CLK_HZ)
`define STAT_PULSE_CYC    16'h0100

`endif

// ===== bench/charger_control_sequencer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module charger_control_sequencer_checker #(
    parameter [39:0] VALID_CYC = 40'h14,
    parameter [39:0] READY_CYC = 40'h14
) (
    input wire logic       SYS_CLK,
    input wire logic       RESETN,
    input wire logic       OTG,
    input wire logic       VBUS_ABOVE_MIN,
    input wire logic       VBUS_OVER,
    input wire logic       SWITCH_EN,
    input wire logic       VBUS_LOAD_EN,
    input wire logic [9:0] SENSE_TARGET,
    input wire logic [9:0] TERM_THRESHOLD,
    input wire logic [1:0] INPUT_LIMIT,
    input wire logic [1:0] CHARGE_STATE,
    input wire logic [2:0] FAULT,
    input wire logic       STAT
);
    logic [39:0] valid_q;
    logic [39:0] ready_q;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);

    // consecutive valid-supply and ready-state cycles at the pins
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            valid_q <= 40'h0;
            ready_q <= 40'h0;
        end else begin
            valid_q <= (VBUS_ABOVE_MIN && !VBUS_OVER) ? valid_q + 40'h1 : 40'h0;
            ready_q <= (CHARGE_STATE == 2'h0) ? ready_q + 40'h1 : 40'h0;
        end
    end

    property p_load; $rose(SWITCH_EN) |-> $past(VBUS_LOAD_EN); endproperty
    a_load: assert property (p_load) else $error("supply load not applied");
    property p_start; $rose(SWITCH_EN) |-> valid_q >= VALID_CYC; endproperty
    a_start: assert property (p_start) else $error("charging began before validation");
    property p_stop; CHARGE_STATE == 2'h0 && $past(CHARGE_STATE) == 2'h1 |-> ##[0:2] !SWITCH_EN; endproperty
    a_stop: assert property (p_stop) else $error("switching kept on in ready");
    property p_ready; $rose(CHARGE_STATE == 2'h2) |-> ready_q + 40'h1 >= READY_CYC; endproperty
    a_ready: assert property (p_ready) else $error("done reported too early");
    property p_sense;
        SENSE_TARGET inside {10'h154, 10'h176, 10'h1BA, 10'h1FE, 10'h242, 10'h2CA, 10'h30E, 10'h396, 10'h3DA};
    endproperty
    a_sense: assert property (p_sense) else $error("sense target off table");
    property p_term; TERM_THRESHOLD inside {10'h21, 10'h42, 10'h63, 10'h84, 10'hA5, 10'hC6, 10'hE7, 10'h108}; endproperty
    a_term: assert property (p_term) else $error("termination threshold off table");
    property p_stat_fault; $rose(STAT) |-> ##[0:2] FAULT == 3'h6; endproperty
    a_stat_fault: assert property (p_stat_fault) else $error("status pulse without timer fault");
    property p_stat_len; $rose(STAT) |=> STAT [*8]; endproperty
    a_stat_len: assert property (p_stat_len) else $error("status pulse too short");
    property p_limit; $rose(STAT) |-> ##[1:6] INPUT_LIMIT == {1'b0, OTG}; endproperty
    a_limit: assert property (p_limit) else $error("input limit not from otg pin");
endmodule

bind charger_control_sequencer charger_control_sequencer_checker #(
    .VALID_CYC(VALID_CYC), .READY_CYC(READY_CYC)) u_checker (
    .SYS_CLK(SYS_CLK), .RESETN(RESETN), .OTG(OTG), .VBUS_ABOVE_MIN(VBUS_ABOVE_MIN), .VBUS_OVER(VBUS_OVER),
    .SWITCH_EN(SWITCH_EN), .VBUS_LOAD_EN(VBUS_LOAD_EN), .SENSE_TARGET(SENSE_TARGET),
    .TERM_THRESHOLD(TERM_THRESHOLD), .INPUT_LIMIT(INPUT_LIMIT), .CHARGE_STATE(CHARGE_STATE),
    .FAULT(FAULT), .STAT(STAT));
`default_nettype wire

// ===== bench/charger_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module charger_host_model (
    output var logic scl,
    output var logic sda_low,
    input  wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // release first so a late ack cannot look like a stop
    task automatic frame_start();
        sda_low = 1'b0;
        #16 scl = 1'b1;
        #8 sda_low = 1'b1;
        #8 scl = 1'b0;
    endtask
    task automatic frame_stop();
        sda_low = 1'b1;
        #8 scl = 1'b1;
        #8 sda_low = 1'b0;
        #16;
    endtask
    // nine bits msb first, a one leaves the line to the pull-up
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_low = !tx[i];
            #8 scl = 1'b1;
            #8 rx[i] = sda;
            #8 scl = 1'b0;
            #8;
        end
    endtask
endmodule
`default_nettype wire

// ===== bench/charger_control_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module charger_control_sequencer_tb;
    localparam [6:0] ADDR = 7'h35;
    logic            sys_clk, rst_n, otg, above, over, term, rech, bat;
    wire logic       scl, host_low, sda, sda_out, sda_oe, switch_en, load_en, stat;
    wire logic [9:0] sense, term_thr;
    wire logic [1:0] in_lim, cstate;
    wire logic [2:0] fault;
    logic [9:0]      tbl [8] = '{10'h176, 10'h1BA, 10'h1FE, 10'h242, 10'h2CA, 10'h30E, 10'h396, 10'h3DA};
    int              fail_count = 0;
    int              check_count = 0;
    int              cyc = 0;

    assign sda = (sda_oe ? sda_out : 1'b1) & !host_low;
    charger_host_model u_host (.scl(scl), .sda_low(host_low), .sda(sda));
    charger_control_sequencer #(.CURRENT_CEILING(3'h6), .VALID_CYC(40'h14), .READY_CYC(40'h3C),
        .WDOG_CYC(40'h3E8), .UNATT_CYC(40'h5DC)) u_dut (
        .SYS_CLK(sys_clk), .RESETN(rst_n), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
        .OTG(otg), .VBUS_ABOVE_MIN(above), .VBUS_OVER(over), .BAT_PRESENT(bat), .TERM_BELOW(term),
        .RECHARGE_REQ(rech), .SWITCH_EN(switch_en), .VBUS_LOAD_EN(load_en), .SENSE_TARGET(sense),
        .TERM_THRESHOLD(term_thr), .INPUT_LIMIT(in_lim), .CHARGE_STATE(cstate), .FAULT(fault), .STAT(stat));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [8:0] r0, r1, r2;
        u_host.frame_start();
        u_host.xfer({ADDR, 2'b01}, r0);
        u_host.xfer({a, 1'b1}, r1);
        u_host.xfer({d, 1'b1}, r2);
        u_host.frame_stop();
        tick(4);
        chk(16'({r0[0], r1[0], r2[0]}), 16'h0);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic [8:0] r;
        u_host.frame_start();
        u_host.xfer({ADDR, 2'b01}, r);
        u_host.xfer({a, 1'b1}, r);
        u_host.frame_start();
        u_host.xfer({ADDR, 2'b11}, r);
        u_host.xfer(9'h1FF, r);
        d = r[8:1];
        u_host.frame_stop();
        tick(4);
    endtask
    task automatic wait_charge(input int lo);
        int n;
        n = 0;
        while (switch_en !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        chk(16'(n >= lo && n < 40), 16'h1);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic t_boot();
        logic [7:0] d;
        logic [7:0] ra [4] = '{8'h01, 8'h04, 8'h05, 8'h03};
        logic [7:0] rv [4] = '{8'h30, 8'h01, 8'h20, 8'h00};
        tick(4);
        chk(16'(load_en), 16'h1);
        wait_charge(16);
        chk(16'(cstate), 16'h1);
        chk(16'(sense), 16'h154);
        chk(16'(term_thr), 16'h42);
        otg = 1'b1;
        tick(6);
        chk(16'(in_lim), 16'h1);
        otg = 1'b0;
        tick(6);
        chk(16'(in_lim), 16'h0);
        for (int i = 0; i < 4; i++) begin
            rd(ra[i], d);
            chk(16'(d), 16'(rv[i]));
        end
        $display("test boot done");
    endtask
    task automatic t_codes();
        logic [7:0] d;
        wr(8'h05, 8'h00);
        for (int c = 0; c < 8; c++) begin
            wr(8'h04, {1'b0, 3'(c), 1'b0, 3'(c)});
            chk(16'(sense), 16'(tbl[c > 6 ? 6 : c]));
            chk(16'(term_thr), 16'h21 * 16'(c + 1));
        end
        rd(8'h04, d);
        chk(16'(d), 16'h67);
        $display("test codes done");
    endtask
    task automatic t_limit();
        otg = 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr(8'h01, {2'(c), 6'h00});
            chk(16'(in_lim), 16'(c));
        end
        $display("test limit done");
    endtask
    task automatic t_term();
        int n;
        term = 1'b1;
        tick(40);
        chk(16'(cstate), 16'h1);
        wr(8'h01, 8'h08);
        chk(16'(cstate), 16'h0);
        chk(16'(switch_en), 16'h0);
        n = 0;
        while (cstate !== 2'h2 && n < 100) begin
            tick(1);
            n++;
        end
        chk(16'(n >= 42 && n <= 46), 16'h1);
        term = 1'b0;
        rech = 1'b1;
        wait_charge(20);
        rech = 1'b0;
        over = 1'b1;
        tick(6);
        chk(16'(switch_en), 16'h0);
        over = 1'b0;
        wait_charge(20);
        bat = 1'b0;
        term = 1'b1;
        tick(90);
        chk(16'(cstate), 16'h0);
        bat = 1'b1;
        term = 1'b0;
        wait_charge(20);
        wr(8'h01, 8'h04);
        chk(16'(switch_en), 16'h0);
        wr(8'h01, 8'h00);
        wait_charge(2);
        $display("test term done");
    endtask
    task automatic t_timers();
        logic [7:0] d;
        int n;
        wr(8'h05, 8'h00);
        wr(8'h01, 8'h40);
        tick(600);
        wr(8'h00, 8'h80);
        tick(700);
        chk(16'(fault), 16'h0);
        n = 0;
        while (stat !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        chk(16'(stat), 16'h1);
        tick(8);
        chk(16'(fault), 16'h6);
        chk(16'(sense), 16'h154);
        chk(16'(term_thr), 16'h42);
        chk(16'(in_lim), 16'h1);
        chk(16'(switch_en), 16'h1);
        n = 0;
        while (switch_en !== 1'b0 && n < 1700) begin
            tick(1);
            n++;
        end
        chk(16'(n > 1400 && n < 1520), 16'h1);
        chk(16'(fault), 16'h6);
        rd(8'h01, d);
        chk(16'(d), 16'h34);
        $display("test timers done");
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        rst_n = 1'b0;
        otg = 1'b0;
        above = 1'b1;
        over = 1'b0;
        term = 1'b0;
        rech = 1'b0;
        bat = 1'b1;
        tick(3);
        rst_n = 1'b1;
        t_boot();
        t_codes();
        t_limit();
        t_term();
        t_timers();
        conclude();
    end
endmodule
`default_nettype wire
